// >>> design/sensor_status_regs.vh
// Offsets, field positions, reset values for the status and error registers
// Assumes inclusion by the status register bank and its helpers
`ifndef SENSOR_STATUS_REGS_VH
`define SENSOR_STATUS_REGS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_DEVICE_IDENTIFIER        8'h00
`define OFS_FAULT_REPORT             8'h02
`define OFS_SENSOR_CONDITION_FLAGS   8'h03
`define OFS_AUX_DATA_FIRST           8'h0a
`define OFS_AUX_DATA_LAST            8'h11
`define OFS_ACC_DATA_FIRST           8'h12
`define OFS_ACC_DATA_LAST            8'h17

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FLT_FATAL_BIT                0
`define FLT_CMD_BIT                  1
`define FLT_CODE_LSB                 2
`define FLT_CODE_MSB                 4
`define FLT_FIFO_BIT                 6
`define FLT_AUX_BIT                  7
`define CND_MANUAL_BIT               2
`define CND_CMD_READY_BIT            4
`define CND_AUX_READY_BIT            5
`define CND_ACC_READY_BIT            7

// ----------------------------------------------------------------------
// Values
// ----------------------------------------------------------------------
`define FAULT_REPORT_RESET           8'h00
`define CONDITION_FLAGS_RESET        8'h10
`define CODE_NO_FAULT                3'h0
`define CODE_ACCEL_CONFIG            3'h1
// Arbitrary neutral identification value
`define DEVICE_ID_VALUE              8'h5a

`endif

// >>> design/sticky_flag.v
// One hardware-set flag cleared by a read or a reset command
// Assumes set and clear pulses on clk_sys_in
`timescale 1ns/100ps
module sticky_flag (
   // Clock and reset
   input  wire clk_sys_in,
   input  wire resetn_in,
   // Control
   input  wire set_in,
   input  wire clear_in,
   // State
   output wire flag_out
);
   reg flag_reg;
   wire flag_next;

   // Set wins over clear
   assign flag_next = set_in | (flag_reg & ~clear_in);

   always @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         flag_reg <= 1'b0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   assign flag_out = flag_reg;
endmodule

// >>> design/level_sync.v
// Three-stage synchroniser, change taken when stages two and three agree
// Assumes an asynchronous level input
`timescale 1ns/100ps
module level_sync (
   // Clock and reset
   input  wire clk_sys_in,
   input  wire resetn_in,
   // Levels
   input  wire async_in,
   output wire level_out
);
   reg s1_reg;
   reg s2_reg;
   reg s3_reg;
   reg level_reg;

   always @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s1_reg    <= 1'b0;
         s2_reg    <= 1'b0;
         s3_reg    <= 1'b0;
         level_reg <= 1'b0;
      end else begin
         s1_reg <= async_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            level_reg <= s3_reg;
         end
      end
   end

   assign level_out = level_reg;
endmodule

// >>> design/sensor_status_error_regs.v
// Identification, fault and condition registers read by the host
// Assumes a byte register port from the serial interface on clk_sys_in
// Function
// [RULE1] Fatal flag bit 0 sets when boot or power leaves chip inoperable.
// [RULE2] Fatal flag survives reads; cleared only by power-on or soft reset.
// [RULE3] Persistent fault code at bits 4:2; 0 none, 1 bad accel configuration. Code follows the input each cycle, back to 0 when it drops.
// [RULE4] Bit 6 sets when streaming FIFO drops samples; cleared by reading.
// [RULE5] Bit 7 sets on auxiliary master error; cleared by reading.
// [RULE6] Condition bit 4 low while command executes, high when ready.
// [RULE7] Condition bit 5 sets on new aux data; cleared by aux data read.
// [RULE8] Condition bit 7 sets on new accel sample; cleared by accel read.
// [RULE9] Condition bit 2 high while manual auxiliary transfer runs.
// [RULE10] Fixed read-only eight-bit identifier at offset 0x00.
// [RULE11] Condition register reads 0x10 after reset.
// [RULE12] Fault register reads 0x00 after reset.
// [RULE13] Writes ignored; reserved bits read zero.
`timescale 1ns/100ps
`include "sensor_status_regs.vh"
module sensor_status_error_regs (
   // Clock and reset
   input  wire       clk_sys_in,
   input  wire       resetn_in,
   // Register port
   input  wire       reg_rd_in,
   input  wire       reg_wr_in,
   input  wire [7:0] reg_addr_in,
   input  wire [7:0] reg_wdata_in,
   output wire [7:0] reg_rdata_out,
   // Soft reset command
   input  wire       soft_reset_in,
   // Fault sources
   input  wire       boot_fault_in,
   input  wire       cmd_fail_in,
   input  wire       accel_configuration_invalid_in,
   input  wire       fifo_drop_in,
   input  wire       aux_error_in,
   // Condition sources
   input  wire       cmd_busy_in,
   input  wire       aux_data_new_in,
   input  wire       acc_data_new_in,
   input  wire       secondary_manual_transfer_active_in
);
   // -------------------------------------------------------------------
   // Read decode
   // -------------------------------------------------------------------
   wire rd_fault;
   wire rd_aux_data;
   wire rd_acc_data;
   wire fatal_clear;

   assign rd_fault    = reg_rd_in & (reg_addr_in == `OFS_FAULT_REPORT);
   assign rd_aux_data = reg_rd_in & (reg_addr_in >= `OFS_AUX_DATA_FIRST)
                        & (reg_addr_in <= `OFS_AUX_DATA_LAST);
   assign rd_acc_data = reg_rd_in & (reg_addr_in >= `OFS_ACC_DATA_FIRST)
                        & (reg_addr_in <= `OFS_ACC_DATA_LAST);
   // Reads do not clear the fatal flag
   assign fatal_clear = soft_reset_in;                       // see [RULE2]

   // -------------------------------------------------------------------
   // Pin-side inputs
   // -------------------------------------------------------------------
   wire boot_fault_s;
   wire manual_s;

   level_sync u_boot_sync (
      .clk_sys_in (clk_sys_in),
      .resetn_in  (resetn_in),
      .async_in   (boot_fault_in),
      .level_out  (boot_fault_s)
   );

   level_sync u_manual_sync (
      .clk_sys_in (clk_sys_in),
      .resetn_in  (resetn_in),
      .async_in   (secondary_manual_transfer_active_in),
      .level_out  (manual_s)
   );

   // -------------------------------------------------------------------
   // Sticky flags
   // -------------------------------------------------------------------
   wire fatal_flag;
   wire cmd_flag;
   wire fifo_flag;
   wire aux_flag;
   wire aux_ready_flag;
   wire acc_ready_flag;

   sticky_flag u_fatal (                                     // see [RULE1]
      .clk_sys_in (clk_sys_in),
      .resetn_in  (resetn_in),
      .set_in     (boot_fault_s),
      .clear_in   (fatal_clear),
      .flag_out   (fatal_flag)
   );

   sticky_flag u_cmd (
      .clk_sys_in (clk_sys_in),
      .resetn_in  (resetn_in),
      .set_in     (cmd_fail_in),
      .clear_in   (rd_fault | soft_reset_in),
      .flag_out   (cmd_flag)
   );

   sticky_flag u_fifo (                                      // see [RULE4]
      .clk_sys_in (clk_sys_in),
      .resetn_in  (resetn_in),
      .set_in     (fifo_drop_in),
      .clear_in   (rd_fault | soft_reset_in),
      .flag_out   (fifo_flag)
   );

   sticky_flag u_aux (                                       // see [RULE5]
      .clk_sys_in (clk_sys_in),
      .resetn_in  (resetn_in),
      .set_in     (aux_error_in),
      .clear_in   (rd_fault | soft_reset_in),
      .flag_out   (aux_flag)
   );

   sticky_flag u_aux_ready (                                 // see [RULE7]
      .clk_sys_in (clk_sys_in),
      .resetn_in  (resetn_in),
      .set_in     (aux_data_new_in),
      .clear_in   (rd_aux_data | soft_reset_in),
      .flag_out   (aux_ready_flag)
   );

   sticky_flag u_acc_ready (                                 // see [RULE8]
      .clk_sys_in (clk_sys_in),
      .resetn_in  (resetn_in),
      .set_in     (acc_data_new_in),
      .clear_in   (rd_acc_data | soft_reset_in),
      .flag_out   (acc_ready_flag)
   );

   // -------------------------------------------------------------------
   // Fault code following accel_configuration_invalid_in and command readiness
   // -------------------------------------------------------------------
   reg [2:0] code_reg;
   reg [2:0] code_next;
   reg       cmd_ready_reg;

   always @* begin
      if (accel_configuration_invalid_in) begin
         code_next = `CODE_ACCEL_CONFIG;                     // see [RULE3]
      end else begin
         code_next = `CODE_NO_FAULT;
      end
   end

   always @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         code_reg      <= `CODE_NO_FAULT;                    // see [RULE12]
         cmd_ready_reg <= 1'b1;                              // see [RULE11]
      end else begin
         code_reg      <= code_next;
         cmd_ready_reg <= ~cmd_busy_in;                      // see [RULE6]
      end
   end

   // -------------------------------------------------------------------
   // Register images
   // -------------------------------------------------------------------
   reg [7:0] fault_image;
   reg [7:0] cond_image;
   reg [7:0] rdata_next;
   reg [7:0] rdata_reg;

   always @* begin
      fault_image = `FAULT_REPORT_RESET;                     // see [RULE13]
      fault_image[`FLT_FATAL_BIT] = fatal_flag;
      fault_image[`FLT_CMD_BIT]   = cmd_flag;
      fault_image[`FLT_CODE_MSB:`FLT_CODE_LSB] = code_reg;
      fault_image[`FLT_FIFO_BIT]  = fifo_flag;
      fault_image[`FLT_AUX_BIT]   = aux_flag;
      cond_image = 8'h00;
      cond_image[`CND_MANUAL_BIT]    = manual_s;             // see [RULE9]
      cond_image[`CND_CMD_READY_BIT] = cmd_ready_reg;
      cond_image[`CND_AUX_READY_BIT] = aux_ready_flag;
      cond_image[`CND_ACC_READY_BIT] = acc_ready_flag;
   end

   // -------------------------------------------------------------------
   // Read data, writes have no effect
   // -------------------------------------------------------------------
   always @* begin
      case (reg_addr_in)
         `OFS_DEVICE_IDENTIFIER:      rdata_next = `DEVICE_ID_VALUE; // see [RULE10]
         `OFS_FAULT_REPORT:           rdata_next = fault_image;
         `OFS_SENSOR_CONDITION_FLAGS: rdata_next = cond_image;
         default:                     rdata_next = 8'h00;
      endcase
   end

   always @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_reg <= 8'h00;
      end else if (reg_rd_in) begin
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata_out = rdata_reg;
endmodule

// >>> testbench/sensor_status_error_regs_checker.sv
// Port checks for the status and fault register bank
// Assumes binding into sensor_status_error_regs, one clock domain
`timescale 1ns/100ps
`include "sensor_status_regs.vh"
module sensor_status_error_regs_checker (
   input wire       clk_sys_in,
   input wire       resetn_in,
   input wire       reg_rd_in,
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_rdata_out,
   input wire       soft_reset_in,
   input wire       boot_fault_in,
   input wire       cmd_fail_in,
   input wire       accel_configuration_invalid_in,
   input wire       fifo_drop_in,
   input wire       aux_error_in,
   input wire       cmd_busy_in,
   input wire       acc_data_new_in
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);
   // ----------------------------------------
   // Sequences and properties
   // ----------------------------------------
   sequence s_rd(logic [7:0] a); reg_rd_in && reg_addr_in == a; endsequence
   sequence s_quiet; !fifo_drop_in && !aux_error_in && !cmd_fail_in; endsequence
   sequence s_clean; s_rd(8'h02) ##0 s_quiet; endsequence
   property p_id; s_rd(8'h00) |=> reg_rdata_out == `DEVICE_ID_VALUE; endproperty
   property p_rsv; reg_rd_in && (reg_addr_in == 8'h02 || reg_addr_in == 8'h03)
      |=> (reg_rdata_out & (($past(reg_addr_in) == 8'h02) ? 8'h20 : 8'h4b)) == 8'h00;
   endproperty
   property p_cmd_ready; s_rd(8'h03) ##0 $stable(cmd_busy_in) && $past(resetn_in)
      |=> reg_rdata_out[4] == !$past(cmd_busy_in); endproperty
   property p_read_clears; s_clean ##1 s_quiet [*2] ##1 s_clean
      |=> reg_rdata_out[7:6] == 2'b00 && !reg_rdata_out[1]; endproperty
   property p_fifo_set; fifo_drop_in ##2 s_rd(8'h02) |=> reg_rdata_out[6]; endproperty
   property p_acc_set; acc_data_new_in ##2 s_rd(8'h03) |=> reg_rdata_out[7]; endproperty
   property p_acc_clear; reg_rd_in && reg_addr_in inside {[8'h12:8'h17]} && !acc_data_new_in
      ##1 !acc_data_new_in [*2] ##1 s_rd(8'h03) |=> !reg_rdata_out[7]; endproperty
   property p_code; s_rd(8'h02) ##0 accel_configuration_invalid_in
      && $past(accel_configuration_invalid_in) && $past(resetn_in)
      |=> reg_rdata_out[4:2] == 3'h1; endproperty
   property p_fatal; boot_fault_in [*5] ##1 (s_rd(8'h02) ##0 !soft_reset_in)
      |=> reg_rdata_out[0]; endproperty
   a_id: assert property (p_id) else $error("identifier mismatch");
   a_rsv: assert property (p_rsv) else $error("reserved bit set");
   a_cmd_ready: assert property (p_cmd_ready) else $error("ready bit wrong");
   a_read_clears: assert property (p_read_clears) else $error("flag kept");
   a_fifo_set: assert property (p_fifo_set) else $error("fifo flag lost");
   a_acc_set: assert property (p_acc_set) else $error("accel ready lost");
   a_acc_clear: assert property (p_acc_clear) else $error("accel ready kept");
   a_code: assert property (p_code) else $error("fault code wrong");
   a_fatal: assert property (p_fatal) else $error("fatal flag missing");
endmodule
bind sensor_status_error_regs sensor_status_error_regs_checker u_chk (.clk_sys_in, .resetn_in,
   .reg_rd_in, .reg_addr_in, .reg_rdata_out, .soft_reset_in, .boot_fault_in, .cmd_fail_in,
   .accel_configuration_invalid_in, .fifo_drop_in, .aux_error_in, .cmd_busy_in,
   .acc_data_new_in);

// >>> testbench/host_reader.sv
// Host model making single-byte register reads and writes
// Assumes the register port samples strobes on the rising clock edge
`timescale 1ns/100ps
module host_reader (
   // Clock
   input  wire       clk_in,
   // Register port
   output reg        rd_out,
   output reg        wr_out,
   output reg  [7:0] addr_out,
   output reg  [7:0] wdata_out,
   input  wire [7:0] rdata_in
);
   initial begin
      rd_out = 1'b0;
      wr_out = 1'b0;
      addr_out = 8'h00;
      wdata_out = 8'h00;
   end
   task read_reg(input [7:0] a, output [7:0] d);
      begin
         @(posedge clk_in);
         rd_out <= 1'b1;
         addr_out <= a;
         @(posedge clk_in);
         rd_out <= 1'b0;
         addr_out <= ~a;
         @(posedge clk_in);
         #1 d = rdata_in;
      end
   endtask
   task write_reg(input [7:0] a, input [7:0] v);
      begin
         @(posedge clk_in);
         wr_out <= 1'b1;
         addr_out <= a;
         wdata_out <= v;
         @(posedge clk_in);
         wr_out <= 1'b0;
         addr_out <= ~a;
         wdata_out <= ~v;
      end
   endtask
endmodule

// >>> testbench/sensor_status_error_regs_tb.sv
// Self-checking bench for the status and fault register bank
// Assumes host_reader as the host and the bound port checker
`timescale 1ns/100ps
`include "sensor_status_regs.vh"
module sensor_status_error_regs_tb;
   reg        clk_sys_in = 1'b0;
   reg        resetn_in = 1'b0;
   reg  [5:0] ev = 6'h00;
   reg  [3:0] lv = 4'h0;
   wire       rd;
   wire       wr;
   wire [7:0] addr;
   wire [7:0] wdata;
   wire [7:0] rdata;
   integer    bad_count = 0;
   integer    comparisons = 0;
   always #2 clk_sys_in = ~clk_sys_in;
   host_reader u_host (.clk_in(clk_sys_in), .rd_out(rd), .wr_out(wr), .addr_out(addr),
      .wdata_out(wdata), .rdata_in(rdata));
   sensor_status_error_regs DUT (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
      .reg_rd_in(rd), .reg_wr_in(wr), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_rdata_out(rdata), .soft_reset_in(ev[5]), .boot_fault_in(lv[3]),
      .cmd_fail_in(ev[0]), .accel_configuration_invalid_in(lv[2]), .fifo_drop_in(ev[1]),
      .aux_error_in(ev[2]), .cmd_busy_in(lv[1]), .aux_data_new_in(ev[3]),
      .acc_data_new_in(ev[4]), .secondary_manual_transfer_active_in(lv[0]));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task check(input [7:0] seen, input [7:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("[FAIL] %0t read 0x%h expected 0x%h", $time, seen, exp);
         end
      end
   endtask
   task rdc(input [7:0] a, input [7:0] exp);
      reg [7:0] d;
      begin
         u_host.read_reg(a, d);
         check(d, exp);
      end
   endtask
   task pulse(input [5:0] m);
      begin
         @(posedge clk_sys_in) ev <= m;
         @(posedge clk_sys_in) ev <= 6'h00;
      end
   endtask
   task level(input [3:0] v);
      begin
         @(posedge clk_sys_in) lv <= v;
         repeat (6) @(posedge clk_sys_in);
      end
   endtask
   task results;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, bad_count);
         if (bad_count == 0 && comparisons > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (2000) @(posedge clk_sys_in);
      bad_count = bad_count + 1;
      results;
   end
   initial begin
      repeat (10) @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      rdc(8'h00, `DEVICE_ID_VALUE);
      rdc(8'h02, 8'h00);
      rdc(8'h03, 8'h10);
      rdc(8'h01, 8'h00);
      u_host.write_reg(8'h02, 8'hff);
      u_host.write_reg(8'h03, 8'h00);
      u_host.write_reg(8'h00, 8'h00);
      rdc(8'h00, `DEVICE_ID_VALUE);
      rdc(8'h03, 8'h10);
      rdc(8'h02, 8'h00);
      pulse(6'h07);
      rdc(8'h02, 8'hc2);
      rdc(8'h02, 8'h00);
      level(4'h4);
      rdc(8'h02, 8'h04);
      level(4'h0);
      rdc(8'h02, 8'h00);
      level(4'h8);
      rdc(8'h02, 8'h01);
      level(4'h0);
      rdc(8'h02, 8'h01);
      pulse(6'h20);
      rdc(8'h02, 8'h00);
      level(4'h2);
      rdc(8'h03, 8'h00);
      level(4'h1);
      rdc(8'h03, 8'h14);
      level(4'h0);
      rdc(8'h03, 8'h10);
      pulse(6'h18);
      rdc(8'h03, 8'hb0);
      rdc(8'h17, 8'h00);
      rdc(8'h03, 8'h30);
      rdc(8'h11, 8'h00);
      rdc(8'h03, 8'h10);
      results;
   end
endmodule
